// [design/tcp_cfg.svh]
// Constants for the timer compare, PWM and delta-sigma block
`ifndef TCP_CFG_SVH
`define TCP_CFG_SVH
`define TCP_CNT_W 16
`define TCP_CNT_RST 16'h0000
`define TCP_FREE_TOP 16'hffff
`define TCP_PRESC_W 7
`define TCP_PRESC_LIM_1 7'h00
`define TCP_PRESC_LIM_8 7'h07
`define TCP_PRESC_LIM_32 7'h1f
`define TCP_PRESC_LIM_128 7'h7f
`define TCP_N_CH 3
`define TCP_F_WRAP 0
`define TCP_F_CH0 1
`define TCP_F_CH1 2
`define TCP_F_CH2 3
`define TCP_N_FLAG 4
`define TCP_FLAG_RST 4'h0
`define TCP_DSM_SUB_W 3
`define TCP_DSM_LAST_4 3'h3
`define TCP_DSM_LAST_8 3'h7
`define TCP_DSM_LSB_DROP 2
`define TCP_DSM_STEP_SH_4 2
`define TCP_DSM_STEP_SH_8 3
`endif

// [design/tcp_cmp_chan.sv]
// One output compare channel: pin set, clear, toggle and PWM edges
`timescale 1ns/100ps
module tcp_cmp_chan
   import tcp_pkg::*;
#(
   parameter bit IS_CH0 = 1'b0
) (
   input wire logic clk,
   input wire logic srst,
   tcp_cnt_if.snk cnt,
   input wire logic [15:0] cmp_value,
   input wire logic [2:0] compare_output_mode,
   output logic match,
   output logic pin
);
   logic pin_q;
   logic pin_d;
   logic at_zero;

   assign match = cnt.run && (cnt.cnt == cmp_value);
   assign at_zero = cnt.run && (cnt.cnt == 16'h0000);

   always_comb begin
      pin_d = pin_q;
      unique case (tcp_cmp_t'(compare_output_mode))
         CM_SET: if (match) pin_d = 1'b1;
         CM_CLR: if (match) pin_d = 1'b0;
         CM_TGL: if (match) pin_d = ~pin_q;
         CM_SET_UP: begin
            if (cnt.updn) begin
               if (match) pin_d = ~cnt.down;
            end else begin
               if (at_zero) pin_d = 1'b0;
               if (match) pin_d = 1'b1;
            end
         end
         CM_CLR_UP: begin
            if (cnt.updn) begin
               if (match) pin_d = cnt.down;
            end else begin
               if (at_zero) pin_d = 1'b1;
               if (match) pin_d = 1'b0;
            end
         end
         CM_SET_TOP: begin
            // Channel 0 value is the period here, so the mode does nothing
            if (!IS_CH0) begin
               if (cnt.term) pin_d = 1'b0;
               if (match) pin_d = 1'b1;
            end
         end
         CM_CLR_TOP: begin
            if (!IS_CH0) begin
               if (cnt.term) pin_d = 1'b1;
               if (match) pin_d = 1'b0;
            end
         end
         CM_DSM: pin_d = pin_q;
      endcase
   end

   // Registered pin keeps every edge glitch-free
   always_ff @(posedge clk) begin
      if (srst) pin_q <= 1'b0;
      else pin_q <= pin_d;
   end

   assign pin = pin_q;
endmodule : tcp_cmp_chan

// [design/tcp_cnt_if.sv]
// Counter state handed from the timer core to its compare channels
`timescale 1ns/100ps
interface tcp_cnt_if;
   logic [15:0] cnt;
   logic run;
   logic updn;
   logic down;
   logic term;
   modport src (output cnt, output run, output updn, output down, output term);
   modport snk (input cnt, input run, input updn, input down, input term);
endinterface : tcp_cnt_if

// [design/tcp_dsm.sv]
// Second-order one-bit delta-sigma modulator with interpolator and shaper
`timescale 1ns/100ps
`include "tcp_cfg.svh"
module tcp_dsm
   import tcp_pkg::*;
#(
   parameter int IW = 20
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic enable,
   input wire logic tick,
   input wire logic rate_eighth,
   input wire logic [1:0] interp_shaper_select,
   input wire logic load,
   input wire logic [15:0] sample,
   output logic bit_out
);
   logic [`TCP_DSM_SUB_W-1:0] sub_q, sub_d, last;
   logic signed [15:0] tgt_q, tgt_d, x_q, x_d, diff;
   logic signed [IW-1:0] i1_q, i1_d, i2_q, i2_d, fb, xw;
   logic bit_q, bit_d, out_q, out_d, upd;

   assign last = rate_eighth ? `TCP_DSM_LAST_8 : `TCP_DSM_LAST_4;
   assign upd = tick && (sub_q == last);
   assign diff = tgt_q - x_q;
   assign fb = bit_q ? (IW'(1) <<< 15) : -(IW'(1) <<< 15);
   assign xw = IW'(x_q);

   always_comb begin
      sub_d = sub_q;
      tgt_d = tgt_q;
      x_d = x_q;
      i1_d = i1_q;
      i2_d = i2_q;
      bit_d = bit_q;
      out_d = out_q;
      if (!enable) begin
         sub_d = '0;
         tgt_d = '0;
         x_d = '0;
         i1_d = '0;
         i2_d = '0;
         bit_d = 1'b0;
         out_d = 1'b0;
      end else begin
         if (tick) sub_d = upd ? '0 : sub_q + 1'b1;
         // Low bits forced to zero, leaving 14 signed bits
         if (load) tgt_d = {sample[15:`TCP_DSM_LSB_DROP], 2'h0};
         if (upd) begin
            if (interp_shaper_select[1]) x_d = tgt_q;
            else if (rate_eighth) x_d = x_q + (diff >>> `TCP_DSM_STEP_SH_8);
            else x_d = x_q + (diff >>> `TCP_DSM_STEP_SH_4);
            i1_d = i1_q + xw - fb;
            i2_d = i2_q + i1_q + xw - fb - fb;
            bit_d = ~i2_d[IW-1];
         end
         // Shaper costs swing but gives each bit one rise and one fall
         if (interp_shaper_select[0]) begin
            if (bit_q) out_d = (sub_d != last);
            else out_d = (sub_d == '0);
         end else begin
            out_d = bit_q;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         sub_q <= '0;
         tgt_q <= '0;
         x_q <= '0;
         i1_q <= '0;
         i2_q <= '0;
         bit_q <= 1'b0;
         out_q <= 1'b0;
      end else begin
         sub_q <= sub_d;
         tgt_q <= tgt_d;
         x_q <= x_d;
         i1_q <= i1_d;
         i2_q <= i2_d;
         bit_q <= bit_d;
         out_q <= out_d;
      end
   end

   assign bit_out = out_q;
endmodule : tcp_dsm

// [design/tcp_pkg.sv]
// Types shared by the timer compare, PWM and delta-sigma modules
package tcp_pkg;
   typedef enum logic [1:0] {
      TM_SUSP = 2'h0,
      TM_FREE = 2'h1,
      TM_MODU = 2'h2,
      TM_UPDN = 2'h3
   } tcp_tmode_t;
   typedef enum logic [2:0] {
      CM_SET = 3'h0,
      CM_CLR = 3'h1,
      CM_TGL = 3'h2,
      CM_SET_UP = 3'h3,
      CM_CLR_UP = 3'h4,
      CM_SET_TOP = 3'h5,
      CM_CLR_TOP = 3'h6,
      CM_DSM = 3'h7
   } tcp_cmp_t;
   function automatic logic tcp_late_apply(input logic [2:0] mode);
      return (mode > 3'h2);
   endfunction : tcp_late_apply
endpackage : tcp_pkg

// [design/tcp_timer.sv]
// Timer core: counter, compare values, channels, flags, requests, modulator
//
// Overview of operation
// - once started, equal counter and compare sets, clears or toggles pin glitch-free.
// - low compare byte is buffered until the high byte is written.
// - modes 0-2 apply a new value at once, others when counter is 0x0000.
// - channel 0 ignores modes 5 and 6; channels 1 and 2 support them.
// - a compare match sets that channel's flag.
// - in up/down counting, channel 0 flag sets at 0x0000, not on match.
// - modulo plus mode 5/6 gives edge PWM, period from channel 0 value.
// - free-running plus mode 5/6 gives PWM with fixed period, duty from value.
// - modes 3 and 4 also give PWM in modulo and free-running counting.
// - up/down plus mode 3/4 gives centre-aligned PWM.
// - one shared timer interrupt line serves all timer events.
// - wrap and channel flags set regardless of the mask bits.
// - pending needs a masked flag; request needs pending and enable.
// - setting a mask while its flag is set makes a new request.
// - modulo/free-running: channel flags on compare or capture, wrap at terminal.
// - up/down compare: ch0 and wrap at zero turnaround; capture: wrap only.
// - three DMA trigger pulses, one per channel compare event.
// - modulator updates at 1/4 or 1/8 tick; samples at channel 0 period in modulo counting.
// - first-order interpolator; select 10/11 gives zeroth order; also shaper.
// - modulator starts the moment channel 1 mode becomes 111.
// - samples are signed, two low bits ignored, 14 effective bits.
// - count mode 00 halt, 01 free, 10 modulo, 11 up/down.
// - any write to the counter low byte clears the counter.
`timescale 1ns/100ps
`include "tcp_cfg.svh"
module tcp_timer
   import tcp_pkg::*;
#(
   parameter int DSM_IW = 20
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic tick,
   input wire logic [1:0] timer_mode,
   input wire logic [1:0] prescale_select,
   input wire logic count_low_wr,
   input wire logic [7:0] chan_wdata,
   input wire logic [2:0] channel_value_low_wr,
   input wire logic [2:0] channel_value_high_wr,
   input wire logic [2:0] chan_is_compare,
   input wire logic [2:0] capture_event,
   input wire logic [2:0] compare_output_mode_0,
   input wire logic [2:0] compare_output_mode_1,
   input wire logic [2:0] compare_output_mode_2,
   input wire logic [2:0] channel_irq_mask,
   input wire logic wrap_irq_mask,
   input wire logic timer_irq_enable,
   input wire logic [3:0] flag_clear,
   input wire logic cpu_pending_clear,
   input wire logic dsm_rate_eighth,
   input wire logic [1:0] interp_shaper_select,
   output logic [15:0] count_value,
   output logic [2:0][15:0] channel_value,
   output logic [2:0] chan_pin,
   output logic wrap_flag,
   output logic chan0_flag,
   output logic chan1_flag,
   output logic chan2_flag,
   output logic cpu_timer_pending,
   output logic timer_irq,
   output logic dma_trig_chan0,
   output logic dma_trig_chan1,
   output logic dma_trig_chan2,
   output logic dsm_active
);
   logic [`TCP_PRESC_W-1:0] presc_q, presc_d, presc_lim;
   logic [15:0] cnt_q, cnt_d, top;
   logic down_q, down_d;
   logic step, run, term, zturn, dsm_on, updn;
   tcp_tmode_t tmode;
   logic [2:0][2:0] cmode;
   logic [2:0][7:0] low_q, low_d;
   logic [2:0][15:0] val_q, val_d, act_q, act_d;
   logic [2:0] match, pin_raw;
   logic [3:0] flags_q, flags_d, set_ev, mask_all, masked, masked_q;
   logic pend_q, pend_d, irq_q, irq_d;
   logic [2:0] dma_q, dma_d;
   logic dsm_bit;

   tcp_cnt_if cnt_bus ();

   assign tmode = tcp_tmode_t'(timer_mode);
   assign updn = (tmode == TM_UPDN);
   assign cmode[0] = compare_output_mode_0;
   assign cmode[1] = compare_output_mode_1;
   assign cmode[2] = compare_output_mode_2;
   assign dsm_on = (tcp_cmp_t'(cmode[1]) == CM_DSM);
   assign top = act_q[0];

   always_comb begin
      unique case (prescale_select)
         2'h0: presc_lim = `TCP_PRESC_LIM_1;
         2'h1: presc_lim = `TCP_PRESC_LIM_8;
         2'h2: presc_lim = `TCP_PRESC_LIM_32;
         2'h3: presc_lim = `TCP_PRESC_LIM_128;
      endcase
   end

   // Prescaler is not cleared on a divider change, so the first period under the new limit counts on from the old count
   always_comb begin
      presc_d = presc_q;
      step = 1'b0;
      if (tick) begin
         if (dsm_on || (presc_q >= presc_lim)) begin
            presc_d = '0;
            step = 1'b1;
         end else begin
            presc_d = presc_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) presc_q <= '0;
      else presc_q <= presc_d;
   end

   assign run = step && (tmode != TM_SUSP);

   always_comb begin
      cnt_d = cnt_q;
      down_d = down_q;
      term = 1'b0;
      zturn = 1'b0;
      if (count_low_wr) begin
         cnt_d = `TCP_CNT_RST;
         down_d = 1'b0;
      end else if (step) begin
         unique case (tmode)
            TM_SUSP: cnt_d = cnt_q;
            TM_FREE: begin
               if (cnt_q == `TCP_FREE_TOP) begin
                  term = 1'b1;
                  cnt_d = `TCP_CNT_RST;
               end else begin
                  cnt_d = cnt_q + 16'h0001;
               end
            end
            TM_MODU: begin
               if (cnt_q >= top) begin
                  term = 1'b1;
                  cnt_d = `TCP_CNT_RST;
               end else begin
                  cnt_d = cnt_q + 16'h0001;
               end
            end
            TM_UPDN: begin
               if (!down_q) begin
                  if (cnt_q >= top) begin
                     down_d = 1'b1;
                     cnt_d = (cnt_q == 16'h0000) ? cnt_q : cnt_q - 16'h0001;
                  end else begin
                     cnt_d = cnt_q + 16'h0001;
                  end
               end else if (cnt_q == 16'h0000) begin
                  zturn = 1'b1;
                  down_d = 1'b0;
                  cnt_d = (top == 16'h0000) ? cnt_q : 16'h0001;
               end else begin
                  cnt_d = cnt_q - 16'h0001;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_q <= `TCP_CNT_RST;
         down_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         down_q <= down_d;
      end
   end

   assign cnt_bus.cnt = cnt_q;
   assign cnt_bus.run = run;
   assign cnt_bus.updn = updn;
   assign cnt_bus.down = down_q;
   assign cnt_bus.term = term;

   // Written value is what software reads; the active copy drives compares
   always_comb begin
      low_d = low_q;
      val_d = val_q;
      act_d = act_q;
      for (int i = 0; i < `TCP_N_CH; i++) begin
         if (channel_value_low_wr[i]) low_d[i] = chan_wdata;
         if (channel_value_high_wr[i]) begin
            val_d[i] = {chan_wdata, low_q[i]};
            if (!tcp_late_apply(cmode[i])) act_d[i] = {chan_wdata, low_q[i]};
         end
         if (tcp_late_apply(cmode[i]) && (cnt_q == 16'h0000)) act_d[i] = val_q[i];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         low_q <= '0;
         val_q <= '0;
         act_q <= '0;
      end else begin
         low_q <= low_d;
         val_q <= val_d;
         act_q <= act_d;
      end
   end

   genvar g;
   generate
      for (g = 0; g < `TCP_N_CH; g++) begin : gen_chan
         tcp_cmp_chan #(
            .IS_CH0(g == 0)
         ) u_chan (
            .clk(clk),
            .srst(srst),
            .cnt(cnt_bus.snk),
            .cmp_value(act_q[g]),
            .compare_output_mode(cmode[g]),
            .match(match[g]),
            .pin(pin_raw[g])
         );
      end
   endgenerate

   tcp_dsm #(
      .IW(DSM_IW)
   ) u_dsm (
      .clk(clk),
      .srst(srst),
      .enable(dsm_on),
      .tick(tick),
      .rate_eighth(dsm_rate_eighth),
      .interp_shaper_select(interp_shaper_select),
      .load(term),
      .sample(act_q[1]),
      .bit_out(dsm_bit)
   );

   always_comb begin
      set_ev[`TCP_F_WRAP] = updn ? zturn : term;
      if (chan_is_compare[0]) set_ev[`TCP_F_CH0] = updn ? zturn : match[0];
      else set_ev[`TCP_F_CH0] = capture_event[0];
      for (int i = 1; i < `TCP_N_CH; i++) begin
         set_ev[`TCP_F_CH0 + i] = chan_is_compare[i] ? match[i] : capture_event[i];
      end
   end

   assign mask_all = {channel_irq_mask, wrap_irq_mask};
   assign masked = flags_q & mask_all;

   // Set beats a clear in the same cycle so no event is dropped
   always_comb begin
      flags_d = (flags_q & ~flag_clear) | set_ev;
      pend_d = (pend_q & ~cpu_pending_clear) | (|(masked & ~masked_q));
      irq_d = pend_d && timer_irq_enable;
      dma_d = match & chan_is_compare;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         flags_q <= `TCP_FLAG_RST;
         masked_q <= 4'h0;
         pend_q <= 1'b0;
         irq_q <= 1'b0;
         dma_q <= 3'h0;
      end else begin
         flags_q <= flags_d;
         masked_q <= masked;
         pend_q <= pend_d;
         irq_q <= irq_d;
         dma_q <= dma_d;
      end
   end

   assign count_value = cnt_q;
   assign channel_value = val_q;
   assign chan_pin = {pin_raw[2], dsm_on ? dsm_bit : pin_raw[1], pin_raw[0]};
   assign wrap_flag = flags_q[`TCP_F_WRAP];
   assign chan0_flag = flags_q[`TCP_F_CH0];
   assign chan1_flag = flags_q[`TCP_F_CH1];
   assign chan2_flag = flags_q[`TCP_F_CH2];
   assign cpu_timer_pending = pend_q;
   assign timer_irq = irq_q;
   assign dma_trig_chan0 = dma_q[0];
   assign dma_trig_chan1 = dma_q[1];
   assign dma_trig_chan2 = dma_q[2];
   assign dsm_active = dsm_on;
endmodule : tcp_timer

// [tb/tcp_pin_load.sv]
// Load on the channel pins: counts channel 1 edges and high cycles
`timescale 1ns/100ps
module tcp_pin_load (
   input wire logic clk,
   input wire logic clr,
   input wire logic [2:0] pin,
   output logic [15:0] edges_q,
   output logic [15:0] highs_q
);
   logic last_q;
   // Pure observer: a real load never drives the timer pins back
   always_ff @(posedge clk) begin
      last_q <= pin[1];
      if (clr) begin
         edges_q <= 16'h0000;
         highs_q <= 16'h0000;
      end else begin
         edges_q <= edges_q + 16'(pin[1] != last_q);
         highs_q <= highs_q + 16'(pin[1]);
      end
   end
endmodule : tcp_pin_load

// [tb/tcp_timer_props.sv]
// Port-level assertions for the timer compare, PWM and delta-sigma block
`timescale 1ns/100ps
module tcp_timer_props (
   input wire logic clk,
   input wire logic srst,
   input wire logic [1:0] timer_mode,
   input wire logic count_low_wr,
   input wire logic [2:0] compare_output_mode_0,
   input wire logic [2:0] compare_output_mode_1,
   input wire logic [2:0] compare_output_mode_2,
   input wire logic [2:0] channel_irq_mask,
   input wire logic wrap_irq_mask,
   input wire logic [2:0] chan_is_compare,
   input wire logic [15:0] count_value,
   input wire logic [2:0] chan_pin,
   input wire logic wrap_flag,
   input wire logic chan0_flag,
   input wire logic chan1_flag,
   input wire logic chan2_flag,
   input wire logic cpu_timer_pending,
   input wire logic timer_irq,
   input wire logic dma_trig_chan1,
   input wire logic dma_trig_chan2,
   input wire logic dsm_active
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   dsm_sel_follow_a: assert property (dsm_active == (compare_output_mode_1 == 3'h7))
      else $error("modulator enable differs from channel 1 mode");
   cnt_clear_a: assert property (count_low_wr |=> count_value == 16'h0000)
      else $error("counter not cleared by low byte write");
   halt_hold_a: assert property (timer_mode == 2'h0 && !count_low_wr |=> $stable(count_value))
      else $error("counter moved while suspended");
   dma_pulse_a: assert property (dma_trig_chan1 |=> !dma_trig_chan1)
      else $error("request pulse longer than one cycle");
   match_flag_a: assert property (dma_trig_chan2 |-> chan2_flag)
      else $error("compare event without channel flag");
   pend_cause_a: assert property ($rose(cpu_timer_pending) |->
      $past(|({chan2_flag, chan1_flag, chan0_flag, wrap_flag} & {channel_irq_mask, wrap_irq_mask})))
      else $error("pending raised without a masked flag");
   irq_gate_a: assert property (timer_irq |-> cpu_timer_pending)
      else $error("request without pending flag");
   mask_new_a: assert property ($rose(channel_irq_mask[1]) && chan1_flag |=> cpu_timer_pending)
      else $error("mask set on raised flag gave no request");
   ch0_no_pwm_a: assert property ($past(compare_output_mode_0) inside {3'h5, 3'h6} |->
      $stable(chan_pin[0]))
      else $error("channel 0 pin moved in an unsupported mode");
   updn_zero_a: assert property ($rose(wrap_flag) && timer_mode == 2'h3 && chan_is_compare[0]
      |-> chan0_flag)
      else $error("zero turnaround without channel 0 flag");
   pin_action_a: assert property (dma_trig_chan2 && $past(compare_output_mode_2) inside {3'h0, 3'h1}
      |-> chan_pin[2] == ($past(compare_output_mode_2) == 3'h0))
      else $error("pin action does not follow compare mode");
   cover property (dma_trig_chan1);
   cover property ($rose(cpu_timer_pending));
   cover property (dsm_active && $changed(chan_pin[1]));
endmodule : tcp_timer_props

// [tb/tcp_timer_test.sv]
// Self-checking bench for the timer compare, PWM and delta-sigma block
`timescale 1ns/100ps
module tcp_timer_test;
   logic clk, srst, tick, count_low_wr, wrap_irq_mask, timer_irq_enable, cpu_pending_clear;
   logic dsm_rate_eighth, ld_clr, wrap_flag, chan0_flag, chan1_flag, chan2_flag;
   logic cpu_timer_pending, timer_irq, dma_trig_chan0, dma_trig_chan1, dma_trig_chan2, dsm_active;
   logic [1:0] timer_mode, prescale_select, interp_shaper_select;
   logic [7:0] chan_wdata;
   logic [2:0] channel_value_low_wr, channel_value_high_wr, chan_is_compare, capture_event;
   logic [2:0] compare_output_mode_0, compare_output_mode_1, compare_output_mode_2;
   logic [2:0] channel_irq_mask, chan_pin;
   logic [3:0] flag_clear;
   logic [15:0] count_value, edges, highs;
   logic [2:0][15:0] channel_value;
   int n_errors, n_checks;
   tcp_timer uut (.*);
   tcp_pin_load u_load (.clk(clk), .clr(ld_clr), .pin(chan_pin), .edges_q(edges), .highs_q(highs));
   task automatic summarize;
      $display("errors=%0d checks=%0d", n_errors, n_checks);
      if (n_errors == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic wr_byte(input logic hi, input int ch, input logic [7:0] b);
      @(posedge clk);
      chan_wdata <= b;
      if (hi) channel_value_high_wr <= 3'h1 << ch;
      else channel_value_low_wr <= 3'h1 << ch;
      @(posedge clk);
      channel_value_high_wr <= 3'h0;
      channel_value_low_wr <= 3'h0;
      #1;
   endtask : wr_byte
   task automatic wr_val(input int ch, input logic [15:0] v);
      wr_byte(1'b0, ch, v[7:0]);
      wr_byte(1'b1, ch, v[15:8]);
   endtask : wr_val
   // Clears counter, flags and pending together so each scenario starts clean
   task automatic restart(input logic [1:0] tm);
      @(posedge clk);
      count_low_wr <= 1'b1;
      timer_mode <= tm;
      flag_clear <= 4'hf;
      cpu_pending_clear <= 1'b1;
      ld_clr <= 1'b1;
      @(posedge clk);
      count_low_wr <= 1'b0;
      flag_clear <= 4'h0;
      cpu_pending_clear <= 1'b0;
      ld_clr <= 1'b0;
      #1;
   endtask : restart
   task automatic pwm(input logic [1:0] tm, input logic [2:0] m, input logic [15:0] exp);
      @(posedge clk);
      compare_output_mode_1 <= m;
      restart(tm);
      cyc(20);
      @(posedge clk);
      ld_clr <= 1'b1;
      @(posedge clk);
      ld_clr <= 1'b0;
      cyc(90);
      #1;
      chk(highs, exp);
   endtask : pwm
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      #2000000;
      n_errors++;
      summarize();
   end
   initial begin
      logic [15:0] v;
      int i;
      {count_low_wr, wrap_irq_mask, timer_irq_enable, cpu_pending_clear, dsm_rate_eighth} = '0;
      {timer_mode, prescale_select, interp_shaper_select, chan_wdata} = '0;
      {channel_value_low_wr, channel_value_high_wr, capture_event, channel_irq_mask} = '0;
      {compare_output_mode_0, compare_output_mode_1, compare_output_mode_2, flag_clear} = '0;
      srst = 1'b1;
      tick = 1'b1;
      ld_clr = 1'b1;
      chan_is_compare = 3'h7;
      cyc(4);
      srst <= 1'b0;
      #1;
      chk(count_value, 16'h0000);
      chk({9'h0, chan_pin, wrap_flag, chan0_flag, chan1_flag, chan2_flag}, 16'h0000);
      wr_byte(1'b0, 1, 8'h05);
      chk(channel_value[1], 16'h0000);
      wr_byte(1'b1, 1, 8'h00);
      chk(channel_value[1], 16'h0005);
      restart(2'h1);
      for (i = 0; i < 100 && chan_pin[1] !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      chk(count_value, 16'h0006);
      chk({14'h0, chan1_flag, cpu_timer_pending}, 16'h0002);
      @(posedge clk);
      channel_irq_mask <= 3'h2;
      timer_irq_enable <= 1'b1;
      cyc(2);
      #1;
      chk({14'h0, cpu_timer_pending, timer_irq}, 16'h0003);
      for (i = 0; i < 3; i++) begin
         @(posedge clk);
         compare_output_mode_2 <= 3'(i);
         wr_val(2, 16'h0010);
         restart(2'h1);
         cyc(20);
         #1;
         chk({15'h0, chan_pin[2]}, 16'(i != 1));
      end
      compare_output_mode_0 <= 3'h5;
      wr_val(0, 16'h0009);
      wr_val(1, 16'h0003);
      v = {15'h0, chan_pin[0]};
      pwm(2'h2, 3'h5, 16'h0036);
      pwm(2'h2, 3'h6, 16'h0024);
      pwm(2'h2, 3'h3, 16'h003f);
      pwm(2'h2, 3'h4, 16'h001b);
      // Free-running period is 65536 steps, so the pin stays set through the window
      pwm(2'h1, 3'h5, 16'h005a);
      chk({15'h0, chan_pin[0]}, v);
      pwm(2'h3, 3'h3, 16'h003c);
      pwm(2'h3, 3'h4, 16'h001e);
      chk({14'h0, wrap_flag, chan0_flag}, 16'h0003);
      prescale_select <= 2'h1;
      restart(2'h1);
      cyc(40);
      #1;
      chk(16'(count_value >= 16'h0005 && count_value <= 16'h0006), 16'h0001);
      v = count_value;
      timer_mode <= 2'h0;
      cyc(1);
      #1;
      v = count_value;
      cyc(10);
      #1;
      chk(count_value, v);
      restart(2'h0);
      @(posedge clk);
      chan_is_compare <= 3'h3;
      capture_event <= 3'h4;
      @(posedge clk);
      capture_event <= 3'h0;
      cyc(1);
      #1;
      chk({15'h0, chan2_flag}, 16'h0001);
      compare_output_mode_0 <= 3'h1;
      prescale_select <= 2'h0;
      compare_output_mode_1 <= 3'h0;
      restart(2'h2);
      wr_val(0, 16'h0040);
      wr_val(1, 16'h2003);
      @(posedge clk);
      interp_shaper_select <= 2'h1;
      dsm_rate_eighth <= 1'b1;
      compare_output_mode_1 <= 3'h7;
      ld_clr <= 1'b1;
      @(posedge clk);
      ld_clr <= 1'b0;
      cyc(200);
      #1;
      chk({15'h0, dsm_active}, 16'h0001);
      // Shaper gives one rise and one fall per bit, so 25 bits make about 50 edges
      chk(16'(edges >= 16'h0028), 16'h0001);
      summarize();
   end
endmodule : tcp_timer_test
bind tcp_timer tcp_timer_props u_props (.*);
